//--- arfc_analog_model.sv
`timescale 1ns/1ps
// Analog front end: the hold capacitor follows the level only while the switch is closed.
module arfc_analog_model (
    input  wire logic       clk_i,
    input  wire logic       sample_i,
    input  wire logic [9:0] level_i,
    output logic      [9:0] code_o
);
    // Charge is frozen once sampling stops, so a late level change cannot leak in.
    always_ff @(posedge clk_i)
    begin
        if (sample_i)
        begin
            code_o <= level_i;
        end
    end
endmodule // arfc_analog_model

//--- arfc_core.sv
`timescale 1ns/1ps
// Functional notes
// - Left justified: result bits 9..2 go to high byte bits 7..0.
// - Left justified: result bits 1..0 in low byte bits 7..6; rest undefined.
// - Right justified: result bits 9..8 in high byte bits 1..0; 7..2 reserved.
// - Right justified: result bits 7..0 fill the low byte.
// - An acquisition interval precedes conversion after channel select.
// - Each sample resolves to one of 1024 codes, a ten-bit result.
// - Timing control bit 7 set selects right, cleared selects left justification.
// - Writing one to busy starts conversion; hardware clears it when done.
// - Acquisition delay codes 0..7 give 0,2,4,6,8,12,16,20 clock periods.
module arfc_core (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [4:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic [arfc_pkg::RESULT_W-1:0] sample_code_i,
    output logic      [arfc_pkg::CH_SEL_W-1:0] input_channel_select_o,
    output logic                               positive_reference_select_o,
    output logic                               negative_reference_select_o,
    output logic                               hold_capacitor_sample_o,
    output logic                               irq_o
);
    import arfc_pkg::*;

    logic [7:0]          channel_control_reg;
    logic [7:0]          reference_control_reg;
    logic [7:0]          timing_control_reg;
    logic [7:0]          result_high_byte;
    logic [7:0]          result_low_byte;
    logic [7:0]          irq_status;
    logic [7:0]          irq_mask;
    logic [RESULT_W-1:0] sample_meta;
    logic [RESULT_W-1:0] sample_sync;
    logic [RESULT_W-1:0] conversion_result;
    arfc_state_e         state;
    logic [4:0]          period_count;
    logic [4:0]          acq_periods;
    logic                tick;
    logic                wr_stb;
    logic                rd_stb;
    logic                start_req;
    logic                conv_done;
    logic                result_justify_select;
    logic                converter_enable;
    logic [2:0]          acquisition_delay_select;
    logic [2:0]          conversion_clock_select;
    logic [7:0]          next_rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // Field views of the control registers.
    assign converter_enable         = channel_control_reg[CH_ENABLE_BIT];
    assign result_justify_select    = timing_control_reg[TM_JUSTIFY_BIT];
    assign acquisition_delay_select = timing_control_reg[TM_ACQ_LSB +: 3];
    assign conversion_clock_select  = timing_control_reg[TM_CLK_LSB +: 3];

    // A bus request is taken in the cycle before ack, and exactly once.
    assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

    // A busy write is honoured only while enabled and idle, so a running
    // conversion is never restarted half way.
    assign start_req = wr_stb && (wb_adr_i == ADDR_CHANNEL_CTRL) && wb_dat_i[CH_BUSY_BIT]
                       && converter_enable && (state == ARFC_IDLE);

    assign conv_done = (state == ARFC_CONVERT) && tick && (period_count == 5'(CONV_PERIODS - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock period divider.
    arfc_tick_gen u_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (state != ARFC_IDLE),
        .clk_sel_i (conversion_clock_select),
        .tick_o    (tick)
    );

    // The analog code comes from another domain and is double synchronised;
    // it is only captured at a settled moment, at end of conversion.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sample_meta <= RESULT_RESET;
            sample_sync <= RESULT_RESET;
        end
        else
        begin
            sample_meta <= sample_code_i;
            sample_sync <= sample_meta;
        end
    end

    // Acquisition delay code to conversion clock periods.
    always_comb
    begin
        case (acquisition_delay_select)
            3'h0:    acq_periods = 5'h00;
            3'h1:    acq_periods = 5'h02;
            3'h2:    acq_periods = 5'h04;
            3'h3:    acq_periods = 5'h06;
            3'h4:    acq_periods = 5'h08;
            3'h5:    acq_periods = 5'h0C;
            3'h6:    acq_periods = 5'h10;
            default: acq_periods = 5'h14;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: acquire for the selected periods, then convert. With a zero
    // delay the acquisition time is left to software.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state        <= ARFC_IDLE;
            period_count <= 5'h00;
        end
        else if (!converter_enable)
        begin
            state        <= ARFC_IDLE;
            period_count <= 5'h00;
        end
        else
        begin
            case (state)
                ARFC_IDLE:
                begin
                    period_count <= 5'h00;
                    if (start_req)
                        state <= (acq_periods == 5'h00) ? ARFC_CONVERT : ARFC_ACQUIRE;
                end
                ARFC_ACQUIRE:
                begin
                    if (tick)
                    begin
                        if (period_count == acq_periods - 5'h01)
                        begin
                            period_count <= 5'h00;
                            state        <= ARFC_CONVERT;
                        end
                        else
                            period_count <= period_count + 5'h01;
                    end
                end
                ARFC_CONVERT:
                begin
                    if (conv_done)
                    begin
                        period_count <= 5'h00;
                        state        <= ARFC_IDLE;
                    end
                    else if (tick)
                        period_count <= period_count + 5'h01;
                end
                default:
                begin
                    state        <= ARFC_IDLE;
                    period_count <= 5'h00;
                end
            endcase
        end
    end

    // Ten-bit result, one of RESULT_CODES values, taken at conversion end.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            conversion_result <= RESULT_RESET;
        else if (conv_done)
            conversion_result <= sample_sync;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel control: busy is set by software, cleared by hardware at the
    // same edge at which the result bytes are loaded.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            channel_control_reg <= CTRL_RESET;
        else
        begin
            if (wr_stb && wb_adr_i == ADDR_CHANNEL_CTRL)
            begin
                channel_control_reg[CH_ENABLE_BIT] <= wb_dat_i[CH_ENABLE_BIT];
                if (state == ARFC_IDLE)
                    channel_control_reg[CH_SEL_LSB +: CH_SEL_W] <=
                        wb_dat_i[CH_SEL_LSB +: CH_SEL_W];
            end
            if (start_req)
                channel_control_reg[CH_BUSY_BIT] <= 1'b1;
            else if (conv_done || !converter_enable)
                channel_control_reg[CH_BUSY_BIT] <= 1'b0;
        end
    end

    // Reference and timing control registers; timing writes are held off
    // during a conversion so the format cannot change mid result.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reference_control_reg <= CTRL_RESET;
            timing_control_reg    <= CTRL_RESET;
        end
        else if (wr_stb)
        begin
            if (wb_adr_i == ADDR_REFERENCE_CTRL)
                reference_control_reg <= wb_dat_i[7:0] & REFERENCE_WMASK;
            if (wb_adr_i == ADDR_TIMING_CTRL && state == ARFC_IDLE)
                timing_control_reg <= wb_dat_i[7:0] & TIMING_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result bytes: both loaded in one edge, justified per the format bit.
    // Software may also write them, as they are plain read/write storage.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            result_high_byte <= 8'h00;
            result_low_byte  <= 8'h00;
        end
        else if (conv_done)
        begin
            if (result_justify_select)
            begin
                result_high_byte <= {6'h00, sample_sync[9:8]};
                result_low_byte  <= sample_sync[7:0];
            end
            else
            begin
                result_high_byte <= sample_sync[9:2];
                result_low_byte  <= {sample_sync[1:0], 6'h00};
            end
        end
        else if (wr_stb)
        begin
            if (wb_adr_i == ADDR_RESULT_HIGH)
                result_high_byte <= wb_dat_i[7:0];
            if (wb_adr_i == ADDR_RESULT_LOW)
                result_low_byte <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Done flag is sticky; a new event wins over a write-one clear.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_status <= 8'h00;
        else
        begin
            if (wr_stb && wb_adr_i == ADDR_IRQ_STATUS)
                irq_status[IRQ_DONE_BIT] <= irq_status[IRQ_DONE_BIT]
                                            & ~wb_dat_i[IRQ_DONE_BIT];
            if (conv_done)
                irq_status[IRQ_DONE_BIT] <= 1'b1;
        end
    end

    // Interrupt mask, same layout as the status register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask <= 8'h00;
        else if (wr_stb && wb_adr_i == ADDR_IRQ_MASK)
            irq_mask <= {7'h00, wb_dat_i[IRQ_DONE_BIT]};
    end

    // Level interrupt; registered so it lags the status bit by one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_status & irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses read as zero and still ack.
    always_comb
    begin
        case (wb_adr_i)
            ADDR_CHANNEL_CTRL:   next_rd_data = channel_control_reg;
            ADDR_REFERENCE_CTRL: next_rd_data = reference_control_reg;
            ADDR_TIMING_CTRL:    next_rd_data = timing_control_reg;
            ADDR_RESULT_HIGH:    next_rd_data = result_high_byte;
            ADDR_RESULT_LOW:     next_rd_data = result_low_byte;
            ADDR_IRQ_STATUS:     next_rd_data = irq_status;
            ADDR_IRQ_MASK:       next_rd_data = irq_mask;
            default:             next_rd_data = 8'h00;
        endcase
    end

    // One wait state answer: ack and data rise one edge after the request.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_stb ? {24'h00_0000, next_rd_data} : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog-facing controls, registered for clean edges.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            input_channel_select_o      <= 4'h0;
            positive_reference_select_o <= 1'b0;
            negative_reference_select_o <= 1'b0;
            hold_capacitor_sample_o     <= 1'b0;
        end
        else
        begin
            input_channel_select_o      <= channel_control_reg[CH_SEL_LSB +: CH_SEL_W];
            positive_reference_select_o <= reference_control_reg[REF_POS_BIT];
            negative_reference_select_o <= reference_control_reg[REF_NEG_BIT];
            hold_capacitor_sample_o     <= converter_enable && (state != ARFC_CONVERT);
        end
    end

endmodule // arfc_core

//--- arfc_core_chk.sv
`timescale 1ns/1ps
// Watches the bus handshake and the control outputs of the converter core, except the negative reference select.
module arfc_core_chk
    import arfc_pkg::*;
(
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [4:0]              wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire logic [RESULT_W-1:0]     sample_code_i,
    input wire logic [CH_SEL_W-1:0]     input_channel_select_o,
    input wire logic                    positive_reference_select_o,
    input wire logic                    negative_reference_select_o,
    input wire logic                    hold_capacitor_sample_o,
    input wire logic                    irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic wr;
    assign req = wb_cyc_i && wb_stb_i;
    assign wr  = req && wb_we_i;
    ////////////////////////////////////////////////////////////////////////////////
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_LATENCY: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_CHAN_CAUSE: assert property ($changed(input_channel_select_o) |->
        $past(wr && wb_adr_i == ADDR_CHANNEL_CTRL, 1)
        || $past(wr && wb_adr_i == ADDR_CHANNEL_CTRL, 2))
        else $error("channel select moved without a write");
    AST_REF_CAUSE: assert property ($changed(positive_reference_select_o) |->
        $past(wr && wb_adr_i == ADDR_REFERENCE_CTRL, 1)
        || $past(wr && wb_adr_i == ADDR_REFERENCE_CTRL, 2))
        else $error("reference select moved without a write");
    AST_IRQ_FALL: assert property ($fell(irq_o) |->
        $past(wb_ack_o && wb_we_i, 1) || $past(wb_ack_o && wb_we_i, 2)
        || $past(wb_ack_o && wb_we_i, 3))
        else $error("interrupt dropped without a write");
    // Main scenarios the bench is expected to reach.
    COV_WRITE: cover property (wr && wb_ack_o);
    COV_IRQ: cover property ($rose(irq_o));
    COV_CONVERT: cover property ($fell(hold_capacitor_sample_o));
endmodule // arfc_core_chk

bind arfc_core arfc_core_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_code_i(sample_code_i), .input_channel_select_o(input_channel_select_o),
    .positive_reference_select_o(positive_reference_select_o),
    .negative_reference_select_o(negative_reference_select_o),
    .hold_capacitor_sample_o(hold_capacitor_sample_o), .irq_o(irq_o));

//--- arfc_pkg.sv
package arfc_pkg;

    // Register word byte addresses on the Wishbone bus.
    localparam logic [4:0] ADDR_CHANNEL_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_REFERENCE_CTRL = 5'h04;
    localparam logic [4:0] ADDR_TIMING_CTRL    = 5'h08;
    localparam logic [4:0] ADDR_RESULT_HIGH    = 5'h0C;
    localparam logic [4:0] ADDR_RESULT_LOW     = 5'h10;
    localparam logic [4:0] ADDR_IRQ_STATUS     = 5'h14;
    localparam logic [4:0] ADDR_IRQ_MASK       = 5'h18;

    // Channel control field positions.
    localparam int CH_ENABLE_BIT = 0;
    localparam int CH_BUSY_BIT   = 1;
    localparam int CH_SEL_LSB    = 2;
    localparam int CH_SEL_W      = 4;

    // Reference control field positions.
    localparam int REF_NEG_BIT = 5;
    localparam int REF_POS_BIT = 4;

    // Timing control field positions.
    localparam int TM_JUSTIFY_BIT = 7;
    localparam int TM_ACQ_LSB     = 3;
    localparam int TM_CLK_LSB     = 0;

    // Writable bit masks for each control register.
    localparam logic [7:0] CHANNEL_WMASK   = 8'h3D;
    localparam logic [7:0] REFERENCE_WMASK = 8'h30;
    localparam logic [7:0] TIMING_WMASK    = 8'hBF;
    localparam logic [7:0] CTRL_RESET      = 8'h00;

    // Result width and the number of codes it spans.
    localparam int          RESULT_W     = 10;
    localparam int          RESULT_CODES = 1024;
    localparam logic [9:0]  RESULT_RESET = 10'h000;

    // Bit periods of conversion plus discharge per sample.
    localparam logic [3:0] CONV_PERIODS = 4'hB;

    // Fixed internal conversion oscillator period in ns, and its cycle count.
    localparam int FRC_PERIOD_NS = 1667;
    localparam int CLK_PERIOD_NS = 20;
    localparam int FRC_CYCLES    = FRC_PERIOD_NS / CLK_PERIOD_NS;

    // Interrupt status bit of the conversion done event.
    localparam int IRQ_DONE_BIT = 0;

    typedef enum logic [1:0] {
        ARFC_IDLE,
        ARFC_ACQUIRE,
        ARFC_CONVERT
    } arfc_state_e;

endpackage

//--- arfc_tick_gen.sv
`timescale 1ns/1ps
// Divides the system clock into one-cycle conversion clock period ticks.
module arfc_tick_gen (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] clk_sel_i,
    output logic            tick_o
);
    import arfc_pkg::*;

    logic [6:0] count;
    logic [6:0] limit;

    ////////////////////////////////////////////////////////////////////////////
    // Divider terminal count per clock select code; both oscillator codes
    // share one count so selection glitches cannot occur.
    always_comb
    begin
        case (clk_sel_i)
            3'h0:    limit = 7'h01;
            3'h1:    limit = 7'h07;
            3'h2:    limit = 7'h1F;
            3'h4:    limit = 7'h03;
            3'h5:    limit = 7'h0F;
            3'h6:    limit = 7'h3F;
            default: limit = 7'(FRC_CYCLES - 1);
        endcase
    end

    // Counter restarts whenever the sequencer is idle so the first period is whole.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i || count >= limit)
            count <= 7'h00;
        else
            count <= count + 7'h01;
    end

    // Tick is registered so the period boundary is a clean pulse.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tick_o <= 1'b0;
        else
            tick_o <= run_i && (count >= limit);
    end

endmodule // arfc_tick_gen

//--- tb_adc_result_format_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_adc_result_format_control;
    import arfc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack, pos, neg, hold, irq;
    logic [9:0] code, level = 10'h000;
    logic [3:0] chan;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    always #10 clk_i = ~clk_i;
    arfc_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .sample_code_i(code), .input_channel_select_o(chan),
        .positive_reference_select_o(pos), .negative_reference_select_o(neg),
        .hold_capacitor_sample_o(hold), .irq_o(irq));
    arfc_analog_model u_model (.clk_i(clk_i), .sample_i(hold), .level_i(level), .code_o(code));
    ////////////////////////////////////////////////////////////////////////////////
    // Conversion clock period in system cycles for each clock select code.
    function automatic int per(input int s);
        case (s)
            0: return 2;
            1: return 8;
            2: return 32;
            4: return 4;
            5: return 16;
            6: return 64;
            default: return 83;
        endcase
    endfunction
    // Expected high and low bytes for a result in either justification.
    function automatic logic [15:0] fmt(input logic [9:0] r, input logic right);
        return right ? {6'h00, r} : {r, 6'h00};
    endfunction
    task automatic complete_run();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Classic single cycle; ack and read data are sampled at the rising edge,
    // and the request is released only after the edge that shows ack high.
    // The master waits without a cycle count; the bench timeout ends a hang.
    task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] s, output logic [7:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {24'h0, d};
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Counts cycles until the sampling output reaches a level.
    task automatic wait_hold(input logic v, output int t);
        t = 0;
        while (hold !== v && t < 5000)
        begin
            @(negedge clk_i);
            t++;
        end
        if (t >= 5000) n_mismatch++;
    endtask
    // A hang is cut short well above the longest expected run.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            $display("[ERR] %0t run timed out", $time);
            complete_run();
        end
    end
    initial
    begin
        logic [7:0] q, hi;
        logic [15:0] e;
        logic rt, msk;
        int n, t1, t2, acq, ck, p, ch;
        n = $urandom(32'h1f5c);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (n = 0; n < 8; n++)
        begin
            wb(5'(n * 4), 1'b0, 8'h00, 4'hF, q);
            `CHK(q, 8'h00)
        end
        $display("test reset values done");
        wb(ADDR_REFERENCE_CTRL, 1'b1, 8'hFF, 4'hF, q);
        wb(ADDR_REFERENCE_CTRL, 1'b0, 8'h00, 4'hF, q);
        `CHK({q, pos, neg}, 10'h0C3)
        wb(ADDR_TIMING_CTRL, 1'b1, 8'hFF, 4'hF, q);
        wb(ADDR_TIMING_CTRL, 1'b0, 8'h00, 4'hF, q);
        `CHK(q, 8'hBF)
        wb(ADDR_CHANNEL_CTRL, 1'b1, 8'hFF, 4'hF, q);
        wb(ADDR_CHANNEL_CTRL, 1'b1, 8'h00, 4'hE, q);
        wb(ADDR_CHANNEL_CTRL, 1'b0, 8'h00, 4'hF, q);
        `CHK({q, chan}, 12'h3DF)
        $display("test write masks done");
        for (int i = 0; i < 12; i++)
        begin
            acq = (i * 3) % 8;
            ck = i % 8;
            p = per(ck);
            ch = $urandom_range(0, 15);
            rt = 1'($urandom_range(0, 1));
            msk = (i % 4 != 3);
            level <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom_range(0, 1023));
            wb(ADDR_IRQ_MASK, 1'b1, {7'h00, msk}, 4'hF, q);
            wb(ADDR_TIMING_CTRL, 1'b1, {rt, 1'b0, 3'(acq), 3'(ck)}, 4'hF, q);
            wb(ADDR_CHANNEL_CTRL, 1'b1, {2'b00, 4'(ch), 2'b01}, 4'hF, q);
            // With no automatic delay, software lets the new channel settle.
            if (acq == 0) repeat (8) @(posedge clk_i);
            wb(ADDR_CHANNEL_CTRL, 1'b1, {2'b00, 4'(ch), 2'b11}, 4'hF, q);
            wait_hold(1'b0, t1);
            wait_hold(1'b1, t2);
            `CHK(t1 >= acq_tab[acq] * p && t1 <= acq_tab[acq] * p + p + 4, 1'b1)
            `CHK(t2 >= 11 * p - 2 && t2 <= 11 * p + 2, 1'b1)
            repeat (2) @(negedge clk_i);
            `CHK(irq, msk)
            wb(ADDR_IRQ_MASK, 1'b1, 8'h01, 4'hF, q);
            repeat (2) @(negedge clk_i);
            `CHK(irq, 1'b1)
            wb(ADDR_CHANNEL_CTRL, 1'b0, 8'h00, 4'hF, q);
            `CHK(q, {2'b00, 4'(ch), 2'b01})
            e = fmt(level, rt);
            wb(ADDR_RESULT_HIGH, 1'b0, 8'h00, 4'hF, hi);
            wb(ADDR_RESULT_LOW, 1'b0, 8'h00, 4'hF, q);
            `CHK(hi, e[15:8])
            `CHK(q, e[7:0])
            `CHK(rt ? {hi[1:0], q} : {hi, q[7:6]}, level)
            wb(ADDR_IRQ_STATUS, 1'b1, 8'h01, 4'hF, q);
            wb(ADDR_IRQ_STATUS, 1'b0, 8'h00, 4'hF, q);
            `CHK({q, irq}, 9'h000)
        end
        $display("test conversions done");
        wb(ADDR_TIMING_CTRL, 1'b1, 8'h3E, 4'hF, q);
        wb(ADDR_CHANNEL_CTRL, 1'b1, 8'h0B, 4'hF, q);
        repeat (20) @(posedge clk_i);
        wb(ADDR_CHANNEL_CTRL, 1'b1, 8'h17, 4'hF, q);
        wb(ADDR_CHANNEL_CTRL, 1'b0, 8'h00, 4'hF, q);
        `CHK({q, chan}, 12'h0B2)
        wb(ADDR_CHANNEL_CTRL, 1'b1, 8'h00, 4'hF, q);
        wb(ADDR_CHANNEL_CTRL, 1'b0, 8'h00, 4'hF, q);
        wb(ADDR_IRQ_STATUS, 1'b0, 8'h00, 4'hF, hi);
        `CHK({q, hi, hold}, 17'h01000)
        $display("test abort done");
        complete_run();
    end
endmodule // tb_adc_result_format_control
